// file: rtl/spc_pkg.sv
// Package for the setpoint and overvoltage control block.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package spc_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets on the Avalon-MM slave.
	// ----------------------------------------------------------------
	localparam logic [5:0] SPC_OFF_CTRL = 6'h00; // Control fields.
	localparam logic [5:0] SPC_OFF_VREQ = 6'h04; // Requested setpoint, mV.
	localparam logic [5:0] SPC_OFF_SETPOINT_STRAP_PIN = 6'h08; // Applied setpoint, mV, read only.
	localparam logic [5:0] SPC_OFF_OVP = 6'h0C; // Overvoltage threshold, mV.
	localparam logic [5:0] SPC_OFF_STATUS = 6'h10; // Fault state, read only.
	localparam logic [5:0] SPC_OFF_COEF_LO = 6'h14; // Coefficient bits 31:0.
	localparam logic [5:0] SPC_OFF_COEF_MID = 6'h18; // Coefficient bits 63:32.
	localparam logic [5:0] SPC_OFF_COEF_HI = 6'h1C; // Coefficient bits 71:64.
	localparam logic [5:0] SPC_OFF_CMD = 6'h20; // Command strobes, write only.
	localparam logic [5:0] SPC_OFF_VOUT = 6'h24; // Measured output, mV.
	localparam logic [5:0] SPC_OFF_WORK_LO = 6'h28; // Working bits 31:0, read only.
	// ----------------------------------------------------------------
	// Control register field positions.
	// ----------------------------------------------------------------
	localparam int SPC_CTRL_TUNE = 0; // Adaptive loop tuning on.
	localparam int SPC_CTRL_OUT_EN = 1; // Output enable request.
	localparam int SPC_CTRL_EXT_SYNC = 2; // External sync clock.
	localparam int SPC_CTRL_RESP = 3; // 0 crowbar, 1 shutdown with retries.
	localparam int SPC_CTRL_RETRY_LSB = 4; // Retry count.
	localparam logic [31:0] SPC_CTRL_RESET = 32'h0000_0001; // Tuning on, crowbar.
	// Command bits.
	localparam int SPC_CMD_STORE = 0; // Save working set to user memory.
	// ----------------------------------------------------------------
	// Coefficient sets.
	// ----------------------------------------------------------------
	localparam int SPC_COEF_W = 72;
	localparam logic [71:0] SPC_COEF_SAFE = 72'h0; // Safe start set, plain default.
	localparam logic [71:0] SPC_COEF_USER_RESET = 72'h0; // User memory on reset.
	// ----------------------------------------------------------------
	// Setpoints and strap.
	// ----------------------------------------------------------------
	localparam int SPC_MV_W = 16;
	localparam int SPC_STRAP_LEVELS = 28;
	localparam logic [15:0] SPC_MV_TIED = 16'd600; // Strap tied to reference.
	localparam logic [15:0] SPC_MV_OPEN = 16'd1200; // Strap floating.
	localparam logic [15:0] SPC_MV_HIGH = 16'd2500; // Strap driven high.
	localparam logic [15:0] SPC_MV_DEFAULT = 16'd600; // Until the strap is sampled.
	localparam int SPC_MAX_PCT = 110; // Limit over strap nominal.
	localparam int SPC_OVP_PCT = 115; // Default threshold over the applied setpoint.
	localparam int SPC_STRAP_SETTLE_CYC = 16; // Strap filter length.
	// Strap modes on the two-bit mode input.
	localparam logic [1:0] SPC_STRAP_RES = 2'h0;
	localparam logic [1:0] SPC_STRAP_TIED = 2'h1;
	localparam logic [1:0] SPC_STRAP_OPEN = 2'h2;
	localparam logic [1:0] SPC_STRAP_HIGH = 2'h3;
	// Fault sequencer states.
	typedef enum logic [3:0] {
		SPC_OFF = 4'b0001,
		SPC_RUN = 4'b0010,
		SPC_FAULT = 4'b0100,
		SPC_LATCHED = 4'b1000
	} spc_state_t;
endpackage

// file: rtl/spc_limit_if.sv
// Interface between the main block and its setpoint limiter.
// Assumes both ends share the block clock.
interface spc_limit_if;
	import spc_pkg::*;
	logic [15:0] request; // Requested setpoint.
	logic [15:0] nominal; // Strap-derived nominal.
	logic [15:0] bin_cap; // Cap from enable-time bin.
	logic enabled; // Output enabled.
	logic [15:0] applied; // Clamped setpoint.
	modport main(output request, output nominal, output bin_cap, output enabled, input applied);
	modport lim(input request, input nominal, input bin_cap, input enabled, output applied);
endinterface

// file: rtl/spc_limiter.sv
// Setpoint limiter: clamps a request to the strap maximum and, while enabled, the bin cap.
// Assumes inputs are stable registers of the same clock.
module spc_limiter
	import spc_pkg::*;
(
	spc_limit_if.lim lim
);
	// Strap maximum is 110 percent of nominal, computed wide then cut.
	wire [31:0] max_wide = (32'(lim.nominal) * 32'(SPC_MAX_PCT)) / 32'd100;
	wire [15:0] strap_max = max_wide[15:0];
	// Enabled: tighter of strap maximum and bin cap; else strap maximum.
	wire [15:0] limit = (lim.enabled && lim.bin_cap < strap_max) ? lim.bin_cap : strap_max;
	// Over-limit requests are clamped, not refused.
	assign lim.applied = (lim.request > limit) ? limit : lim.request;
endmodule

// file: rtl/spc_top.sv
// Setpoint and overvoltage control block.
// Assumes an Avalon-MM master and an analog strap encoder.
//
// Summary of operation
// - Tuning off loads user coefficients into working.
// - Power-up loads the safe set, since tuning resets on.
// - Strap sampled only at start-up.
// - Strap resistor gives one of 28 setpoints.
// - Tied 0.60, open 1.2, high 2.5 volts.
// - Host setpoint replaces strap setpoint.
// - Never exceed 110 percent of strap nominal.
// - Enabled output capped by enable-time bin.
// - Disabled output uses strap maximum only.
// - Fault above threshold, default 115 percent.
// - Shutdown response retries a chosen number of times.
// - Crowbar holds low side on until restart.
// - Crowbar response after reset.
// - Restart automatically once fault clears, unless shutdown retries are spent.
// - External sync forces immediate shutdown response.
// - Host writes threshold and response; applied.
// - Power-up with tuning on loads safe set.
// - Tuning switched on loads safe set.
module spc_top
	import spc_pkg::*;
#(
	parameter int RETRY_W = 4
) (
	// Clock and reset.
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	// Avalon-MM slave.
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Strap encoder from the analog side.
	input wire logic [1:0] STRAP_MODE_IN,
	input wire logic [4:0] STRAP_INDEX_IN,
	// Overvoltage comparator level from the analog side.
	input wire logic [15:0] VOUT_MV_IN,
	// Power stage and loop.
	output logic HIGH_SIDE_EN_OUT,
	output logic LOW_SIDE_ON_OUT,
	output logic [15:0] SETPOINT_MV_OUT,
	output logic [15:0] OVP_MV_OUT,
	output logic [71:0] WORK_COEF_OUT,
	output logic FAULT_OUT
);
	// ----------------------------------------------------------------
	// Resistor strap table.
	// ----------------------------------------------------------------
	// Millivolts per resistor position, lowest first.
	function automatic logic [15:0] strap_mv(input logic [4:0] idx);
		logic [15:0] v;
		v = 16'd3300; // Indices past the table saturate at the top level.
		case (idx)
			5'd0: v = 16'd600; 5'd1: v = 16'd650; 5'd2: v = 16'd700; 5'd3: v = 16'd750;
			5'd4: v = 16'd800; 5'd5: v = 16'd850; 5'd6: v = 16'd900; 5'd7: v = 16'd950;
			5'd8: v = 16'd1000; 5'd9: v = 16'd1050; 5'd10: v = 16'd1100; 5'd11: v = 16'd1150;
			5'd12: v = 16'd1200; 5'd13: v = 16'd1250; 5'd14: v = 16'd1300; 5'd15: v = 16'd1400;
			5'd16: v = 16'd1500; 5'd17: v = 16'd1600; 5'd18: v = 16'd1700; 5'd19: v = 16'd1800;
			5'd20: v = 16'd1900; 5'd21: v = 16'd2000; 5'd22: v = 16'd2100; 5'd23: v = 16'd2200;
			5'd24: v = 16'd2300; 5'd25: v = 16'd2500; 5'd26: v = 16'd3000; 5'd27: v = 16'd3300;
			default: v = 16'd3300;
		endcase
		return v;
	endfunction

	// Enable-time bin maps to the allowed setpoint cap.
	function automatic logic [15:0] bin_cap_mv(input logic [15:0] mv);
		logic [15:0] c;
		if (mv <= 16'd988) begin
			c = 16'd1200;
		end else if (mv <= 16'd1383) begin
			c = 16'd1700;
		end else if (mv <= 16'd1975) begin
			c = 16'd2500;
		end else if (mv <= 16'd2398) begin
			c = 16'd2970;
		end else if (mv <= 16'd2963) begin
			c = 16'd3680;
		end else begin
			c = 16'd4650;
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// Strap synchronisers and start-up sampling.
	// ----------------------------------------------------------------
	// Three-stage synchronisers; stages two and three must agree.
	logic [6:0] strap_s1, strap_s2, strap_s3;
	logic [15:0] vout_s1, vout_s2, vout_s3;
	logic [15:0] vout_mv; // Accepted output voltage.
	wire strap_stable = (strap_s2 == strap_s3);
	always_ff @(posedge SYS_CLK_IN) begin
		strap_s1 <= {STRAP_MODE_IN, STRAP_INDEX_IN};
		strap_s2 <= strap_s1;
		strap_s3 <= strap_s2;
		vout_s1 <= VOUT_MV_IN;
		vout_s2 <= vout_s1;
		vout_s3 <= vout_s2;
	end

	// Output voltage updates only when two stages agree, so a skewed bus is not taken.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			vout_mv <= 16'h0000;
		end else if (vout_s2 == vout_s3) begin
			vout_mv <= vout_s3;
		end
	end

	// Strap decode from the synchronised mode and index.
	wire [1:0] strap_mode = strap_s3[6:5];
	wire [15:0] strap_decoded =
		(strap_mode == SPC_STRAP_TIED) ? SPC_MV_TIED :
		(strap_mode == SPC_STRAP_OPEN) ? SPC_MV_OPEN :
		(strap_mode == SPC_STRAP_HIGH) ? SPC_MV_HIGH : strap_mv(strap_s3[4:0]);

	// Captures a quiet strap once, then never looks again.
	logic [4:0] settle_cnt;
	logic strap_done;
	logic [15:0] nominal_mv;
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			settle_cnt <= 5'h00;
			strap_done <= 1'b0;
			nominal_mv <= SPC_MV_DEFAULT;
		end else if (!strap_done) begin
			if (!strap_stable) begin
				settle_cnt <= 5'h00;
			end else if (settle_cnt == 5'(SPC_STRAP_SETTLE_CYC - 1)) begin
				strap_done <= 1'b1;
				nominal_mv <= strap_decoded;
			end else begin
				settle_cnt <= settle_cnt + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave with one wait state.
	// ----------------------------------------------------------------
	// Waitrequest drops for one cycle to answer.
	logic ack;
	wire req = (AVS_READ_IN || AVS_WRITE_IN) && !ack;
	wire wr_fire = AVS_WRITE_IN && ack;
	wire [31:0] be_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
		{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction

	// Control register fields.
	logic [31:0] ctrl;
	logic [15:0] vreq_mv;
	logic [15:0] ovp_mv;
	logic ovp_user; // Host has written the threshold.
	logic vreq_user; // Host has written a setpoint.
	logic [71:0] coef_reg; // Staging word written by the host.
	logic [71:0] user_coef; // User nonvolatile copy.
	logic [71:0] work_coef; // Working coefficients.
	logic boot_loaded; // Power-up load done.
	logic tune_q; // Tuning state last cycle.

	wire sel_ctrl = AVS_ADDRESS_IN == SPC_OFF_CTRL;
	wire sel_vreq = AVS_ADDRESS_IN == SPC_OFF_VREQ;
	wire sel_ovp = AVS_ADDRESS_IN == SPC_OFF_OVP;
	wire sel_clo = AVS_ADDRESS_IN == SPC_OFF_COEF_LO;
	wire sel_cmid = AVS_ADDRESS_IN == SPC_OFF_COEF_MID;
	wire sel_chi = AVS_ADDRESS_IN == SPC_OFF_COEF_HI;
	wire sel_cmd = AVS_ADDRESS_IN == SPC_OFF_CMD;
	wire store_cmd = wr_fire && sel_cmd && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[SPC_CMD_STORE];
	wire tune_en = ctrl[SPC_CTRL_TUNE];
	wire out_en_req = ctrl[SPC_CTRL_OUT_EN];
	// External sync overrides the host's response choice.
	wire resp_shutdown = ctrl[SPC_CTRL_RESP] || ctrl[SPC_CTRL_EXT_SYNC];
	wire [RETRY_W-1:0] retry_limit = ctrl[SPC_CTRL_RETRY_LSB +: RETRY_W];

	// Waitrequest generator.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	// Register writes; they act at once.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			ctrl <= SPC_CTRL_RESET;
			vreq_mv <= 16'h0000;
			ovp_mv <= 16'h0000;
			ovp_user <= 1'b0;
			vreq_user <= 1'b0;
			coef_reg <= SPC_COEF_USER_RESET;
		end else if (wr_fire) begin
			if (sel_ctrl) begin
				ctrl <= merge(ctrl, AVS_WRITEDATA_IN, be_mask) & 32'h0000_00FF;
			end
			if (sel_vreq) begin
				vreq_mv <= 16'(merge({16'h0000, vreq_mv}, AVS_WRITEDATA_IN, be_mask));
				vreq_user <= 1'b1;
			end
			if (sel_ovp) begin
				ovp_mv <= 16'(merge({16'h0000, ovp_mv}, AVS_WRITEDATA_IN, be_mask));
				ovp_user <= 1'b1;
			end
			if (sel_clo) begin
				coef_reg[31:0] <= merge(coef_reg[31:0], AVS_WRITEDATA_IN, be_mask);
			end
			if (sel_cmid) begin
				coef_reg[63:32] <= merge(coef_reg[63:32], AVS_WRITEDATA_IN, be_mask);
			end
			if (sel_chi) begin
				coef_reg[71:64] <= 8'(merge({24'h000000, coef_reg[71:64]}, AVS_WRITEDATA_IN, be_mask));
			end
		end
	end

	// ----------------------------------------------------------------
	// Coefficient memories.
	// ----------------------------------------------------------------
	// Staging writes reach working memory a cycle later, once the merged word stands.
	// Store copies working to user memory; a same-cycle tuning change saves the old set.
	wire coef_wr = wr_fire && (sel_clo || sel_cmid || sel_chi);
	logic coef_wr_q; // A staging write landed last cycle.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			user_coef <= SPC_COEF_USER_RESET;
			work_coef <= SPC_COEF_SAFE;
			boot_loaded <= 1'b0;
			tune_q <= 1'b1;
			coef_wr_q <= 1'b0;
		end else begin
			tune_q <= tune_en;
			coef_wr_q <= coef_wr;
			if (store_cmd) begin
				user_coef <= work_coef;
			end
			if (!boot_loaded) begin
				boot_loaded <= 1'b1;
				work_coef <= tune_en ? SPC_COEF_SAFE : user_coef;
			end else if (tune_q && !tune_en) begin
				work_coef <= user_coef;
			end else if (!tune_q && tune_en) begin
				work_coef <= SPC_COEF_SAFE;
			end else if (coef_wr_q) begin
				work_coef <= coef_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Setpoint and threshold.
	// ----------------------------------------------------------------
	spc_limit_if lim_if();
	logic out_on; // Output currently enabled.
	logic [15:0] bin_cap;
	assign lim_if.request = vreq_user ? vreq_mv : nominal_mv;
	assign lim_if.nominal = nominal_mv;
	assign lim_if.bin_cap = bin_cap;
	assign lim_if.enabled = out_on;
	spc_limiter u_lim (
		.lim(lim_if.lim)
	);

	// Default threshold tracks the applied setpoint.
	wire [31:0] ovp_wide = (32'(lim_if.applied) * 32'(SPC_OVP_PCT)) / 32'd100;
	wire [15:0] ovp_limit = ovp_user ? ovp_mv : ovp_wide[15:0];
	wire ov_now = strap_done && (vout_mv > ovp_limit);

	// ----------------------------------------------------------------
	// Overvoltage fault sequencer.
	// ----------------------------------------------------------------
	spc_state_t state, next_state;
	logic [RETRY_W-1:0] retries;
	wire retry_left = retries < retry_limit;
	always_comb begin
		next_state = state;
		unique case (state)
			SPC_OFF: if (strap_done && out_en_req && boot_loaded) next_state = SPC_RUN;
			SPC_RUN: begin
				if (!out_en_req) begin
					next_state = SPC_OFF;
				end else if (ov_now) begin
					next_state = SPC_FAULT;
				end
			end
			SPC_FAULT: begin
				if (!out_en_req) begin
					next_state = SPC_OFF;
				end else if (!ov_now) begin
					// Crowbar restarts without limit; shutdown spends retries.
					next_state = (!resp_shutdown || retry_left) ? SPC_RUN : SPC_LATCHED;
				end
			end
			SPC_LATCHED: if (!out_en_req) next_state = SPC_OFF;
			default: next_state = SPC_OFF;
		endcase
	end

	// State, retries and the enable-time bin, frozen while on.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			state <= SPC_OFF;
			retries <= '0;
			bin_cap <= 16'hFFFF;
			out_on <= 1'b0;
		end else begin
			state <= next_state;
			out_on <= (next_state == SPC_RUN);
			if (state == SPC_OFF && next_state == SPC_RUN) begin
				bin_cap <= bin_cap_mv(lim_if.applied);
				retries <= '0;
			end else if (state == SPC_FAULT && next_state == SPC_RUN && resp_shutdown) begin
				retries <= retries + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs.
	// ----------------------------------------------------------------
	// Crowbar holds the low side on through the fault; shutdown leaves both off.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			HIGH_SIDE_EN_OUT <= 1'b0;
			LOW_SIDE_ON_OUT <= 1'b0;
			SETPOINT_MV_OUT <= 16'h0000;
			OVP_MV_OUT <= 16'h0000;
			WORK_COEF_OUT <= SPC_COEF_SAFE;
			FAULT_OUT <= 1'b0;
		end else begin
			HIGH_SIDE_EN_OUT <= (next_state == SPC_RUN);
			LOW_SIDE_ON_OUT <= (next_state == SPC_FAULT) && !resp_shutdown;
			SETPOINT_MV_OUT <= lim_if.applied;
			OVP_MV_OUT <= ovp_limit;
			WORK_COEF_OUT <= work_coef;
			FAULT_OUT <= (next_state == SPC_FAULT) || (next_state == SPC_LATCHED);
		end
	end

	// Read mux; unmapped addresses read zero.
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl :
		sel_vreq ? {16'h0000, vreq_mv} :
		(AVS_ADDRESS_IN == SPC_OFF_SETPOINT_STRAP_PIN) ? {16'h0000, lim_if.applied} :
		sel_ovp ? {16'h0000, ovp_limit} :
		(AVS_ADDRESS_IN == SPC_OFF_STATUS) ? {24'h000000, strap_done, out_on, 2'b00, state} :
		sel_clo ? coef_reg[31:0] :
		sel_cmid ? coef_reg[63:32] :
		sel_chi ? {24'h000000, coef_reg[71:64]} :
		(AVS_ADDRESS_IN == SPC_OFF_VOUT) ? {16'h0000, vout_mv} :
		(AVS_ADDRESS_IN == SPC_OFF_WORK_LO) ? work_coef[31:0] : 32'h0000_0000;

	// Read data is taken on the request cycle and held.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			AVS_READDATA_OUT <= 32'h0000_0000;
			AVS_WAITREQUEST_OUT <= 1'b1;
		end else begin
			if (req && AVS_READ_IN) begin
				AVS_READDATA_OUT <= rd_mux;
			end
			AVS_WAITREQUEST_OUT <= !req;
		end
	end
endmodule

// file: tb/spc_strap_model.sv
// Far-side model: strap encoder and the measured output level.
// Tasks are called just after a rising clock edge.
module spc_strap_model (
	// Clock.
	input wire logic clk_in,
	// Strap and output level seen by the block.
	output logic [1:0] mode_out,
	output logic [4:0] index_out,
	output logic [15:0] vout_out
);
	// Strap reads resistor position zero and the output sits at ground.
	initial begin
		mode_out = 2'h0;
		index_out = 5'h00;
		vout_out = 16'h0000;
	end
	// Strap changes land by non-blocking assignment.
	task automatic set_strap(input logic [1:0] m, input logic [4:0] i);
		mode_out <= m;
		index_out <= i;
	endtask
	// The level holds, so a fault stays present.
	task automatic set_vout(input logic [15:0] v);
		vout_out <= v;
	endtask
endmodule

// file: tb/spc_top_checker.sv
// Checker for spc_top: bus, power stage, limits and faults.
// Bound to spc_top; one clock, synchronous active-high reset.
module spc_top_checker
	import spc_pkg::*;
#(
	parameter int RETRY_W = 4
) (
	// Clock, reset and bus.
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	// Analog side and power stage.
	input wire logic [1:0] STRAP_MODE_IN,
	input wire logic [4:0] STRAP_INDEX_IN,
	input wire logic [15:0] VOUT_MV_IN,
	input wire logic HIGH_SIDE_EN_OUT,
	input wire logic LOW_SIDE_ON_OUT,
	input wire logic [15:0] SETPOINT_MV_OUT,
	input wire logic [15:0] OVP_MV_OUT,
	input wire logic [71:0] WORK_COEF_OUT,
	input wire logic FAULT_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// Cycles since reset; start-up is over once it tops out.
	logic [5:0] cyc;
	// Output above the active threshold, unsynchronised.
	wire logic over = VOUT_MV_IN > OVP_MV_OUT;
	// Saturates, so it never wraps into the start-up window.
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			cyc <= 6'h00;
		end else if (cyc != 6'h3F) begin
			cyc <= cyc + 6'h01;
		end
	end
	property p_wait_one; (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT; endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer late");
	property p_wait_pulse; !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT; endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("bus answer too long");
	property p_max; SETPOINT_MV_OUT <= 16'h0E2E; endproperty
	a_max: assert property (p_max) else $error("setpoint above top limit");
	property p_coef_boot; $past(SYS_RST_IN) |-> WORK_COEF_OUT == SPC_COEF_SAFE; endproperty
	a_coef_boot: assert property (p_coef_boot) else $error("start coefficients wrong");
	property p_sp_hold;
		cyc == 6'h3F && $changed(SETPOINT_MV_OUT) |-> $past(AVS_WRITE_IN) || $past(AVS_WRITE_IN, 2) || $past(AVS_WRITE_IN, 3);
	endproperty
	a_sp_hold: assert property (p_sp_hold) else $error("setpoint moved without a write");
	property p_fault_hs; FAULT_OUT |-> !HIGH_SIDE_EN_OUT; endproperty
	a_fault_hs: assert property (p_fault_hs) else $error("high side on in fault");
	property p_crowbar; LOW_SIDE_ON_OUT |-> FAULT_OUT && !HIGH_SIDE_EN_OUT; endproperty
	a_crowbar: assert property (p_crowbar) else $error("low side on outside fault");
	property p_trip; over && HIGH_SIDE_EN_OUT |-> ##[1:8] (FAULT_OUT || !HIGH_SIDE_EN_OUT); endproperty
	a_trip: assert property (p_trip) else $error("overvoltage not acted on");
	property p_hold; $rose(FAULT_OUT) && over |=> FAULT_OUT; endproperty
	a_hold: assert property (p_hold) else $error("fault left while present");
	c_fault: cover property ($rose(FAULT_OUT));
	c_crowbar: cover property (LOW_SIDE_ON_OUT);
	c_write: cover property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT);
endmodule
bind spc_top spc_top_checker #(.RETRY_W(RETRY_W)) u_chk (
	.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
	.AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
	.AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .STRAP_MODE_IN(STRAP_MODE_IN),
	.STRAP_INDEX_IN(STRAP_INDEX_IN), .VOUT_MV_IN(VOUT_MV_IN), .HIGH_SIDE_EN_OUT(HIGH_SIDE_EN_OUT),
	.LOW_SIDE_ON_OUT(LOW_SIDE_ON_OUT), .SETPOINT_MV_OUT(SETPOINT_MV_OUT), .OVP_MV_OUT(OVP_MV_OUT),
	.WORK_COEF_OUT(WORK_COEF_OUT), .FAULT_OUT(FAULT_OUT)
);

// file: tb/spc_top_tb.sv
// Bench for spc_top: strap, limits, coefficients, faults.
// Assumes the strap model and the bound checker.
module spc_top_tb
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] m; logic [4:0] i; logic [15:0] nom; logic [15:0] req; logic [15:0] exp;} spc_row_t;
	localparam logic [71:0] UNI = 72'h7C_F84D_FE85_807D_8F26;
	logic clk, rst, rd, wr, wait_q, hs, ls, flt;
	logic [5:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [1:0] smode;
	logic [4:0] sidx;
	logic [3:0] be;
	logic [15:0] vout, sp, overvoltage_protection;
	logic [71:0] coef;
	int num_errors = 0;
	int cmp_count = 0;
	// Strap, nominal, request, expected applied value.
	spc_row_t rows[8] = '{'{2'h0, 5'h00, 16'h0258, 16'h02BC, 16'h0294}, '{2'h0, 5'h0A, 16'h044C, 16'h0514, 16'h04BA},
		'{2'h0, 5'h1B, 16'h0CE4, 16'h0BB8, 16'h0BB8}, '{2'h0, 5'h19, 16'h09C4, 16'h0ABE, 16'h0ABE},
		'{2'h1, 5'h05, 16'h0258, 16'h028A, 16'h028A}, '{2'h2, 5'h00, 16'h04B0, 16'h0578, 16'h0528},
		'{2'h3, 5'h00, 16'h09C4, 16'h2328, 16'h0ABE}, '{2'h0, 5'h0E, 16'h0514, 16'h03E8, 16'h03E8}};
	spc_top uut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_q),
		.STRAP_MODE_IN(smode), .STRAP_INDEX_IN(sidx), .VOUT_MV_IN(vout), .HIGH_SIDE_EN_OUT(hs),
		.LOW_SIDE_ON_OUT(ls), .SETPOINT_MV_OUT(sp), .OVP_MV_OUT(overvoltage_protection), .WORK_COEF_OUT(coef), .FAULT_OUT(flt));
	spc_strap_model model (.clk_in(clk), .mode_out(smode), .index_out(sidx), .vout_out(vout));
	// 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Four-state compare, so an unknown never passes.
	task automatic chk(input string name, input logic [71:0] e, input logic [71:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", name, e, g);
		end
	endtask
	// One bus cycle, held until waitrequest is sampled low; outputs settle after.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		be <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (wait_q !== 1'b0 && n < 50);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// Bounded wait on fault (sel 1) or high side (sel 0).
	task automatic wait_chk(input string name, input bit sel, input logic v);
		int n;
		n = 0;
		while ((sel ? flt : hs) !== v && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(name, v, sel ? flt : hs);
	endtask
	// Two-cycle reset, then poll until the strap is taken.
	task automatic do_reset(input logic [1:0] m, input logic [4:0] i);
		int n;
		n = 0;
		model.set_strap(m, i);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		do begin
			bus(1'b0, SPC_OFF_STATUS, 32'h0, q);
			n++;
		end while (q[7] !== 1'b1 && n < 40);
	endtask
	// Single end of run for the tests and the watchdog.
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog, far past the test length.
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		{rst, rd, wr, addr, wdata} = {1'b1, 1'b0, 1'b0, 6'h00, 32'h0};
		@(posedge clk);
		foreach (rows[k]) begin
			do_reset(rows[k].m, rows[k].i);
			chk("strap setpoint", rows[k].nom, sp);
			chk("default threshold", 72'(rows[k].nom * SPC_OVP_PCT / 100), overvoltage_protection);
			bus(1'b1, SPC_OFF_VREQ, {16'h0000, rows[k].req}, q);
			bus(1'b0, SPC_OFF_SETPOINT_STRAP_PIN, 32'h0, q);
			chk("applied", rows[k].exp, q[15:0]);
			$display("row %0d done", k);
		end
		model.set_strap(2'h3, 5'h1B);
		repeat (40) @(posedge clk);
		chk("strap hold", 16'h03E8, sp);
		bus(1'b1, SPC_OFF_COEF_LO, 32'h807D_8F26, q);
		bus(1'b1, SPC_OFF_COEF_MID, 32'hF84D_FE85, q);
		bus(1'b1, SPC_OFF_COEF_HI, 32'h0000_007C, q);
		chk("staged coef", UNI, coef);
		bus(1'b1, SPC_OFF_CMD, 32'h0000_0001, q);
		bus(1'b1, SPC_OFF_COEF_HI, 32'h0000_0000, q);
		bus(1'b1, SPC_OFF_CTRL, 32'h0, q);
		chk("tuning off coef", UNI, coef);
		bus(1'b0, SPC_OFF_WORK_LO, 32'h0, q);
		chk("working low", 32'h807D_8F26, q);
		bus(1'b1, SPC_OFF_CTRL, 32'h1, q);
		chk("tuning on coef", SPC_COEF_SAFE, coef);
		$display("coefficient test done");
		// Crowbar response at a host threshold of 1200 mV.
		bus(1'b1, SPC_OFF_OVP, 32'h0000_04B0, q);
		bus(1'b0, SPC_OFF_OVP, 32'h0, q);
		chk("threshold", 32'h0000_04B0, q);
		model.set_vout(16'h03E8);
		bus(1'b1, SPC_OFF_CTRL, 32'h2, q);
		wait_chk("run", 1'b0, 1'b1);
		bus(1'b1, SPC_OFF_VREQ, 32'h0000_05DC, q);
		chk("enabled limit", 16'h0596, sp);
		model.set_vout(16'h0514);
		wait_chk("crowbar fault", 1'b1, 1'b1);
		chk("crowbar low side", 1'b1, ls);
		bus(1'b0, SPC_OFF_STATUS, 32'h0, q);
		chk("fault state", 4'h4, q[3:0]);
		model.set_vout(16'h03E8);
		wait_chk("crowbar restart", 1'b0, 1'b1);
		$display("crowbar test done");
		// Shutdown response with one retry, then latched off.
		bus(1'b1, SPC_OFF_CTRL, 32'h1A, q);
		model.set_vout(16'h0514);
		wait_chk("shutdown fault", 1'b1, 1'b1);
		chk("shutdown low side", 1'b0, ls);
		model.set_vout(16'h03E8);
		wait_chk("retry", 1'b0, 1'b1);
		model.set_vout(16'h0514);
		wait_chk("second fault", 1'b1, 1'b1);
		model.set_vout(16'h03E8);
		repeat (30) @(posedge clk);
		chk("latched", 1'b1, flt);
		bus(1'b0, SPC_OFF_STATUS, 32'h0, q);
		chk("latched state", 4'h8, q[3:0]);
		bus(1'b1, SPC_OFF_CTRL, 32'h0, q);
		wait_chk("cleared", 1'b1, 1'b0);
		// External sync forces plain shutdown.
		bus(1'b1, SPC_OFF_CTRL, 32'h6, q);
		wait_chk("sync run", 1'b0, 1'b1);
		model.set_vout(16'h0514);
		wait_chk("sync fault", 1'b1, 1'b1);
		chk("sync low side", 1'b0, ls);
		model.set_vout(16'h03E8);
		bus(1'b1, SPC_OFF_CTRL, 32'h0, q);
		// Read-only and unmapped places.
		bus(1'b1, SPC_OFF_SETPOINT_STRAP_PIN, 32'h0, q);
		bus(1'b0, SPC_OFF_SETPOINT_STRAP_PIN, 32'h0, q);
		chk("read only", 32'h0000_0596, q);
		bus(1'b0, 6'h3C, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("fault and bus tests done");
		tally_and_finish();
	end
endmodule
